// file: verilog/dual_timer.sv
/*
  Two independent counter/timers with 13-bit, 16-bit and 8-bit
  auto-reload modes, a shared prescaler, pin synchronisers and overflow
  flags. Assumes one system clock; pins are asynchronous to it.
*/
`timescale 1ns/1ps
`include "timer_cfg.svh"

// Notes on behaviour
// - Each timer keeps a 16-bit count written and read as low and high bytes.
// - Each timer has its own mode field; the two are set independently.
// - With source select set, each falling edge on the event pin counts once.
// - Event edges up to a quarter of the system clock rate are counted.
// - Without source select, count every clock or on prescaler ticks.
// - In 13-bit mode high byte holds upper eight bits, low byte five.
// - 13-bit wrap from 1FFF to 0 sets the flag and may interrupt.
// - Count only when run and either gate off or gate input active.
// - Each gate input has its own polarity bit.
// - Setting run leaves the count untouched.
// - The second timer mirrors the first with its own bytes and pins.
// - 16-bit mode counts all sixteen bits, enabled as in 13-bit mode.
// - 8-bit mode: low byte wraps, sets flag, reloads from high byte.
// - The reload leaves the high byte unchanged.
// - Overflow interrupt is raised only when its enable bit is set.
module dual_timer (
  // Clock, reset and clock enable
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // Pins, index 0 for timer a, 1 for timer b
  input wire logic [1:0] event_pin_i,
  input wire logic [1:0] gate_input_i,
  // Configuration
  input wire timer_pkg::timer_cfg_t [1:0] cfg_i,
  input wire logic [1:0] clock_scale_i,
  // Software byte access
  input wire logic [1:0] low_wr_i,
  input wire logic [1:0] high_wr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [1:0] flag_clr_i,
  // Status
  output timer_pkg::timer_count_t [1:0] count_o,
  output logic [1:0] overflow_flag_o,
  output logic [1:0] irq_o
);

  timer_pkg::top_state_t state_q;
  timer_pkg::top_state_t state_d;
  logic [1:0] ev_fall;
  logic [1:0] tick;
  logic [1:0] enabled;
  logic [1:0] ovf;
  logic presc_tick;
  logic [5:0] presc_div;

  // --------------------------------------------------------------------------
  // Prescaler divisor
  // --------------------------------------------------------------------------
  always_comb begin
    case (clock_scale_i)
      2'h0: presc_div = `TMR_DIV_SCALE0;
      2'h1: presc_div = `TMR_DIV_SCALE1;
      2'h2: presc_div = `TMR_DIV_SCALE2;
      default: presc_div = `TMR_DIV_SCALE3;
    endcase
  end

  assign presc_tick = (state_q.presc >= presc_div - 6'h01);

  // --------------------------------------------------------------------------
  // Next state: synchronisers, sampled levels, prescaler, flags
  // --------------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    state_d.presc = presc_tick ? `TMR_PRESC_RST : state_q.presc + 6'h01;
    for (int i = 0; i < 2; i++) begin
      // Only stage two reads stage one; stages two and three vote on a level.
      state_d.ev_sync[i] = {state_q.ev_sync[i][1:0], event_pin_i[i]};
      state_d.gate_sync[i] = {state_q.gate_sync[i][1:0], gate_input_i[i]};
      if (state_q.ev_sync[i][1] == state_q.ev_sync[i][2]) begin
        state_d.ev_lvl[i] = state_q.ev_sync[i][2];
      end
      if (state_q.gate_sync[i][1] == state_q.gate_sync[i][2]) begin
        state_d.gate_lvl[i] = state_q.gate_sync[i][2];
      end
      // A set in the same cycle as a clear wins, so no overflow is lost.
      if (ovf[i]) begin
        state_d.flag[i] = 1'b1;
      end else if (flag_clr_i[i]) begin
        state_d.flag[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= '{ev_sync: {`TMR_SYNC_RST, `TMR_SYNC_RST},
                   gate_sync: {`TMR_SYNC_RST, `TMR_SYNC_RST},
                   ev_lvl: `TMR_LVL_RST,
                   gate_lvl: `TMR_LVL_RST,
                   presc: `TMR_PRESC_RST,
                   flag: `TMR_FLAG_RST};
    end else if (ce_i) begin
      state_q <= state_d;
    end
  end

  // --------------------------------------------------------------------------
  // Per-timer enable, clock source and count unit
  // --------------------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_timer
    // A level held two clocks is seen once, so a quarter-rate input counts.
    // Reading only registered stages keeps the overflow path free of loops.
    assign ev_fall[g] = state_q.ev_lvl[g] & ~state_q.ev_sync[g][1]
                        & ~state_q.ev_sync[g][2];
    // Run alone never touches the count; it only gates the tick.
    assign enabled[g] = cfg_i[g].run & (~cfg_i[g].gate_enable |
                        (state_q.gate_lvl[g] == cfg_i[g].gate_polarity));
    assign tick[g] = enabled[g] & (cfg_i[g].source_select ? ev_fall[g] :
                     (cfg_i[g].clock_select | presc_tick));

    timer_unit u_unit (
      .clock_i(clock_i),
      .nrst_i(nrst_i),
      .ce_i(ce_i),
      .mode_i(cfg_i[g].mode),
      .tick_i(tick[g] & ce_i),
      .low_wr_i(low_wr_i[g]),
      .high_wr_i(high_wr_i[g]),
      .wr_data_i(wr_data_i),
      .count_o(count_o[g]),
      .ovf_o(ovf[g])
    );

    assign irq_o[g] = state_q.flag[g] & cfg_i[g].int_enable;
  end

  assign overflow_flag_o = state_q.flag;

  // --------------------------------------------------------------------------
  // Checks, mostly on timer a
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  logic quiet_a;
  assign quiet_a = ~low_wr_i[0] & ~high_wr_i[0];

  a_hold_not_run: assert property (
    !cfg_i[0].run && quiet_a |=> $stable(count_o[0]))
    else $error("Timer a count moved while not running.");

  a_gate_blocks_count: assert property (
    cfg_i[0].gate_enable && (state_q.gate_lvl[0] != cfg_i[0].gate_polarity) && quiet_a
    |=> $stable(count_o[0]))
    else $error("Timer a counted with its gate inactive.");

  a_flag_on_wrap: assert property (
    ovf[0] && ce_i |=> overflow_flag_o[0])
    else $error("Timer a overflow did not set its flag.");

  a_irq_needs_enable: assert property (
    irq_o[0] |-> cfg_i[0].int_enable && overflow_flag_o[0])
    else $error("Timer a interrupt without enable or flag.");

  a_reload_value: assert property (
    ce_i && tick[0] && quiet_a && cfg_i[0].mode == timer_pkg::MODE_8RELOAD
    && count_o[0].low == 8'hFF |=> count_o[0].low == $past(count_o[0].high) && overflow_flag_o[0])
    else $error("Timer a did not reload its low byte.");

  a_reload_keeps_high: assert property (
    cfg_i[0].mode == timer_pkg::MODE_8RELOAD && !high_wr_i[0] |=> $stable(count_o[0].high))
    else $error("Timer a reload changed the high byte.");

  a_sysclk_step: assert property (
    ce_i && enabled[0] && !cfg_i[0].source_select && cfg_i[0].clock_select && quiet_a
    && cfg_i[0].mode == timer_pkg::MODE_16BIT
    |=> count_o[0] == $past(count_o[0]) + 16'h0001)
    else $error("Timer a did not step on the system clock.");

  a_event_step: assert property (
    ce_i && enabled[0] && cfg_i[0].source_select && ev_fall[0] && quiet_a
    && cfg_i[0].mode == timer_pkg::MODE_16BIT
    |=> count_o[0] == $past(count_o[0]) + 16'h0001)
    else $error("Timer a missed a falling event edge.");

  a_low_top_bits: assert property (
    cfg_i[0].mode == timer_pkg::MODE_13BIT && !low_wr_i[0]
    |=> $stable(count_o[0].low[7:5]))
    else $error("Timer a 13-bit count touched low byte bits 7 to 5.");

  a_event_latency: assert property (
    ce_i && $fell(state_q.ev_sync[0][2]) && state_q.ev_sync[0][1] == 1'b0
    && state_q.ev_lvl[0] |-> ev_fall[0])
    else $error("Timer a event edge not seen after agreement.");

  a_presc_wait: assert property (
    ce_i && enabled[0] && !cfg_i[0].source_select && !cfg_i[0].clock_select && !presc_tick
    && quiet_a |=> $stable(count_o[0]))
    else $error("Timer a counted between prescaler ticks.");

  a_event_needs_edge: assert property (
    ce_i && enabled[0] && cfg_i[0].source_select && !ev_fall[0] && quiet_a
    |=> $stable(count_o[0]))
    else $error("Timer a counted without an event edge.");

  a_gate_opens: assert property (
    ce_i && cfg_i[0].run && cfg_i[0].gate_enable && !cfg_i[0].source_select
    && cfg_i[0].clock_select && (state_q.gate_lvl[0] == cfg_i[0].gate_polarity) && quiet_a
    && cfg_i[0].mode == timer_pkg::MODE_16BIT
    |=> count_o[0] == $past(count_o[0]) + 16'h0001)
    else $error("Timer a did not count with its gate active.");

  a_b_wrap_13bit: assert property (
    ce_i && tick[1] && !low_wr_i[1] && !high_wr_i[1]
    && cfg_i[1].mode == timer_pkg::MODE_13BIT
    && (&{count_o[1].high, count_o[1].low[4:0]})
    |=> {count_o[1].high, count_o[1].low[4:0]} == 13'h0000 && overflow_flag_o[1])
    else $error("Timer b 13-bit wrap did not clear the count and set the flag.");

  a_b_flag_set: assert property (
    ovf[1] && ce_i |=> overflow_flag_o[1])
    else $error("Timer b overflow did not set its flag.");

endmodule : dual_timer

// file: verilog/timer_cfg.svh
/*
  Constants of the dual counter/timer: reset values, prescaler divisors and
  synchroniser depth. Assumes a single system clock of 250 MHz.
*/
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH

// ----------------------------------------------------------------------------
// Clock and pin sampling
// ----------------------------------------------------------------------------
`define TMR_CLK_MHZ 16'h00FA
`define TMR_SYNC_STAGES 3
`define TMR_SYNC_RST 3'h0

// ----------------------------------------------------------------------------
// Prescaler divisors selected by the clock scale field
// ----------------------------------------------------------------------------
`define TMR_DIV_SCALE0 6'h0C
`define TMR_DIV_SCALE1 6'h04
`define TMR_DIV_SCALE2 6'h30
`define TMR_DIV_SCALE3 6'h08
`define TMR_PRESC_RST 6'h00

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define TMR_BYTE_RST 8'h00
`define TMR_FLAG_RST 2'h0
`define TMR_LVL_RST 2'h0

`endif

// file: verilog/timer_pkg.sv
/*
  Types of the dual counter/timer: modes, per-timer configuration, count
  bytes and the register state of both modules. Assumes timer_cfg.svh.
*/
package timer_pkg;

  // --------------------------------------------------------------------------
  // Modes and configuration
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_13BIT,
    MODE_16BIT,
    MODE_8RELOAD,
    MODE_HOLD
  } timer_mode_t;

  typedef struct packed {
    timer_mode_t mode;
    logic gate_enable;
    logic source_select;
    logic clock_select;
    logic run;
    logic gate_polarity;
    logic int_enable;
  } timer_cfg_t;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } timer_count_t;

  // --------------------------------------------------------------------------
  // Register state of the top module
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0][2:0] ev_sync;
    logic [1:0][2:0] gate_sync;
    logic [1:0] ev_lvl;
    logic [1:0] gate_lvl;
    logic [5:0] presc;
    logic [1:0] flag;
  } top_state_t;

endpackage : timer_pkg

// file: verilog/timer_unit.sv
/*
  One counter/timer: the count bytes, the mode-dependent increment and the
  software byte writes. Assumes the caller supplies a one-cycle count tick.
*/
`timescale 1ns/1ps
`include "timer_cfg.svh"

module timer_unit (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // Control
  input wire timer_pkg::timer_mode_t mode_i,
  input wire logic tick_i,
  // Software byte access
  input wire logic low_wr_i,
  input wire logic high_wr_i,
  input wire logic [7:0] wr_data_i,
  // Status
  output timer_pkg::timer_count_t count_o,
  output logic ovf_o
);

  timer_pkg::timer_count_t state_q;
  timer_pkg::timer_count_t state_d;

  // --------------------------------------------------------------------------
  // Count logic
  // --------------------------------------------------------------------------
  always_comb begin
    logic [12:0] n13;
    logic [15:0] n16;
    n13 = {state_q.high, state_q.low[4:0]} + 13'h0001;
    n16 = {state_q.high, state_q.low} + 16'h0001;
    state_d = state_q;
    ovf_o = 1'b0;
    if (tick_i) begin
      case (mode_i)
        timer_pkg::MODE_13BIT: begin
          // The upper three low-byte bits are left alone; they carry no count.
          state_d.high = n13[12:5];
          state_d.low[4:0] = n13[4:0];
          ovf_o = &{state_q.high, state_q.low[4:0]};
        end
        timer_pkg::MODE_16BIT: begin
          {state_d.high, state_d.low} = n16;
          ovf_o = &{state_q.high, state_q.low};
        end
        timer_pkg::MODE_8RELOAD: begin
          if (&state_q.low) begin
            state_d.low = state_q.high;
            ovf_o = 1'b1;
          end else begin
            state_d.low = state_q.low + 8'h01;
          end
        end
        default: begin
          state_d = state_q;
        end
      endcase
    end
    // A software write wins over the count in the same cycle.
    if (low_wr_i) begin
      state_d.low = wr_data_i;
    end
    if (high_wr_i) begin
      state_d.high = wr_data_i;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= {`TMR_BYTE_RST, `TMR_BYTE_RST};
    end else if (ce_i) begin
      state_q <= state_d;
    end
  end

  assign count_o = state_q;

endmodule : timer_unit

// file: verification/pin_source.sv
/*
  Far-side model of the event and gate pins of both timers.
  Assumes the bench calls its tasks from one process at a time.
*/
`timescale 1ns/1ps

module pin_source (
  // Clock
  input wire logic clock_i,
  // Pins
  output logic [1:0] event_pin_o,
  output logic [1:0] gate_input_o
);
  initial begin
    event_pin_o = 2'h3;
    gate_input_o = 2'h3;
  end

  // Each level stands two clocks, the fastest rate that is still counted.
  task automatic pulses(input int idx, input int n);
    repeat (n) begin
      repeat (2) @(posedge clock_i);
      #1;
      event_pin_o[idx] = 1'b0;
      repeat (2) @(posedge clock_i);
      #1;
      event_pin_o[idx] = 1'b1;
    end
  endtask : pulses

  task automatic set_gate(input int idx, input logic v);
    @(posedge clock_i);
    #1;
    gate_input_o[idx] = v;
  endtask : set_gate
endmodule : pin_source

// file: verification/dual_timer_bench.sv
/*
  Self-checking bench of the dual counter/timer.
  Assumes pin_source drives the pins; ce_i is low only in the freeze step.
*/
`timescale 1ns/1ps

module dual_timer_bench;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic ce = 1'b1;
  logic [1:0] ev;
  logic [1:0] gt;
  timer_pkg::timer_cfg_t [1:0] cfg = '0;
  logic [1:0] scale = 2'h1;
  logic [1:0] lo_wr = 2'h0;
  logic [1:0] hi_wr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic [1:0] fclr = 2'h0;
  timer_pkg::timer_count_t [1:0] cnt;
  logic [1:0] flag;
  logic [1:0] irq;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;

  dual_timer i_dut (.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce),
    .event_pin_i(ev), .gate_input_i(gt), .cfg_i(cfg), .clock_scale_i(scale),
    .low_wr_i(lo_wr), .high_wr_i(hi_wr), .wr_data_i(wdata), .flag_clr_i(fclr),
    .count_o(cnt), .overflow_flag_o(flag), .irq_o(irq));
  pin_source i_pins (.clock_i(clock_i), .event_pin_o(ev), .gate_input_o(gt));

  initial begin
    forever #2 clock_i = ~clock_i;
  end

  // A hang would otherwise stall the run; the tests need under 1000 cycles.
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      final_report();
    end
  end

  task automatic step(input int n);
    repeat (n) begin
      @(posedge clock_i);
      #1;
    end
  endtask : step

  task automatic chk_count(input int i, input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t count %0d got %h exp %h", $time, i, got, exp);
    end
  endtask : chk_count

  task automatic chk_bits(input logic [1:0] got, input logic [1:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t flags got %b exp %b", $time, got, exp);
    end
  endtask : chk_bits

  task automatic wr(input int i, input logic [7:0] hi, input logic [7:0] lo);
    lo_wr[i] = 1'b1;
    wdata = lo;
    step(1);
    lo_wr[i] = 1'b0;
    hi_wr[i] = 1'b1;
    wdata = hi;
    step(1);
    hi_wr[i] = 1'b0;
    step(1);
  endtask : wr

  task automatic clr(input int i);
    fclr[i] = 1'b1;
    step(1);
    fclr[i] = 1'b0;
    step(1);
  endtask : clr

  task automatic run_for(input int i, input int n);
    cfg[i].run = 1'b1;
    step(n);
    cfg[i].run = 1'b0;
    step(2);
  endtask : run_for

  task automatic t_16bit;
    cfg[0] = '{mode: timer_pkg::MODE_16BIT, clock_select: 1'b1, int_enable: 1'b1,
      default: 1'b0};
    wr(0, 8'hFF, 8'hFE);
    chk_count(0, cnt[0], 16'hFFFE);
    run_for(0, 3);
    chk_count(0, cnt[0], 16'h0001);
    chk_bits(flag, 2'h1);
    chk_bits(irq, 2'h1);
    clr(0);
    chk_bits(flag, 2'h0);
    $display("test 16bit done");
  endtask : t_16bit

  task automatic t_13bit;
    cfg[1] = '{mode: timer_pkg::MODE_13BIT, clock_select: 1'b1, default: 1'b0};
    wr(1, 8'hFF, 8'h1F);
    run_for(1, 2);
    chk_count(1, {cnt[1].high, 3'h0, cnt[1].low[4:0]}, 16'h0001);
    chk_bits(flag, 2'h2);
    chk_bits(irq, 2'h0);
    clr(1);
    $display("test 13bit done");
  endtask : t_13bit

  task automatic t_reload;
    cfg[0].mode = timer_pkg::MODE_8RELOAD;
    wr(0, 8'hF0, 8'hFE);
    run_for(0, 3);
    chk_count(0, cnt[0], 16'hF0F1);
    chk_bits(flag, 2'h1);
    clr(0);
    $display("test reload done");
  endtask : t_reload

  task automatic t_gate;
    cfg[0] = '{mode: timer_pkg::MODE_16BIT, clock_select: 1'b1, gate_enable: 1'b1,
      default: 1'b0};
    wr(0, 8'h00, 8'h00);
    run_for(0, 5);
    chk_count(0, cnt[0], 16'h0000);
    i_pins.set_gate(0, 1'b0);
    step(6);
    run_for(0, 4);
    chk_count(0, cnt[0], 16'h0004);
    cfg[0].gate_polarity = 1'b1;
    run_for(0, 4);
    chk_count(0, cnt[0], 16'h0004);
    $display("test gate done");
  endtask : t_gate

  task automatic t_presc;
    cfg[0] = '{mode: timer_pkg::MODE_16BIT, default: 1'b0};
    wr(0, 8'h00, 8'h00);
    run_for(0, 40);
    chk_count(0, cnt[0], 16'h000A);
    // Divisors only grow from window to window, so each window holds whole periods.
    scale = 2'h3;
    run_for(0, 40);
    chk_count(0, cnt[0], 16'h000F);
    scale = 2'h0;
    run_for(0, 48);
    chk_count(0, cnt[0], 16'h0013);
    scale = 2'h2;
    run_for(0, 48);
    chk_count(0, cnt[0], 16'h0014);
    cfg[0].clock_select = 1'b1;
    ce = 1'b0;
    run_for(0, 8);
    ce = 1'b1;
    chk_count(0, cnt[0], 16'h0014);
    $display("test prescale done");
  endtask : t_presc

  task automatic t_event;
    for (int i = 0; i < 2; i++) begin
      cfg[i] = '{mode: timer_pkg::MODE_16BIT, source_select: 1'b1, run: 1'b1,
        default: 1'b0};
      wr(i, 8'h00, 8'h00);
      i_pins.pulses(i, 4);
      step(8);
      cfg[i].run = 1'b0;
      chk_count(i, cnt[i], 16'h0004);
    end
    $display("test event done");
  endtask : t_event

  task automatic t_reset;
    cfg[0] = '{mode: timer_pkg::MODE_16BIT, clock_select: 1'b1, int_enable: 1'b1,
      default: 1'b0};
    wr(0, 8'hFF, 8'hFE);
    run_for(0, 3);
    chk_bits(irq, 2'h1);
    nrst_i = 1'b0;
    step(2);
    nrst_i = 1'b1;
    step(1);
    chk_count(0, cnt[0], 16'h0000);
    chk_count(1, cnt[1], 16'h0000);
    chk_bits(flag, 2'h0);
    chk_bits(irq, 2'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  initial begin
    step(6);
    nrst_i = 1'b1;
    step(1);
    chk_count(0, cnt[0], 16'h0000);
    chk_bits(flag, 2'h0);
    t_16bit();
    t_13bit();
    t_reload();
    t_gate();
    t_presc();
    t_event();
    t_reset();
    final_report();
  end
endmodule : dual_timer_bench
